// ### hw/ldprb_pkg.sv
package ldprb_pkg;

  // Register byte offsets on the AXI4-Lite slave
  localparam int AXI_AW = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_WCNT = 8'h08;

  // Control register layout
  localparam int CTRL_BITS = 13;
  localparam int CTRL_WIDTH_LSB = 0;
  localparam int CTRL_MODE_LSB = 3;
  localparam int CTRL_CLK_LSB = 5;
  localparam int CTRL_LANE8 = 7;
  localparam int CTRL_BYP_A = 8;
  localparam int CTRL_BYP_B = 9;
  localparam int CTRL_MSK_A = 10;
  localparam int CTRL_MSK_B = 11;
  localparam int CTRL_SPLIT = 12;
  localparam logic [12:0] CTRL_RST = 13'h0003;
  localparam int STAT_ERR = 0;

  // Shape codes: lanes per word is 1 << code
  localparam logic [2:0] W_X9 = 3'h0;
  localparam logic [2:0] W_X144 = 3'h4;
  localparam logic [1:0] MODE_TDP = 2'h0;
  localparam logic [1:0] MODE_SDP = 2'h1;
  localparam logic [1:0] MODE_SP = 2'h2;
  localparam logic [1:0] CLK_INDEP = 2'h0;
  localparam logic [1:0] CLK_IO = 2'h1;
  localparam logic [1:0] CLK_RW = 2'h2;
  localparam logic [1:0] MODE_BAD = 2'h3;

  // Array geometry
  localparam int NLANES = 16;
  localparam int PORT_DW = 72;
  localparam int PORT_MW = 8;
  localparam int LANE_IW = 16;
  localparam int DEPTH = 65536;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### hw/ldprb_top.sv
// Overview of operation
// - A port writes only with write-enable high; mask bits gate lanes.
// - Lane masks count as all ones in x9, and in other shapes unless software enables mask use.
// - Lane masking exists in x18, x36 and x72, using 2, 4 and 8 bits.
// - In x144 the mask is port B bits over port A bits, 16 total.
// - Mask bit i enables write data bits 9i+8 down to 9i.
// - In x144, combined mask bit i enables bits 9i+8..9i, i up to 15.
// - Any mix of mask bits is accepted; exactly those lanes are written.
// - With 8-bit lanes selected, mask bit i covers bits 8i+7..8i.
// - A port's input registers all load on one shared enable.
// - Read data output register can be bypassed per port.
// - Each port has 72 write-data inputs and 72 read-data outputs.
// - Address in low and high bytes, 8-bit mask, read/write select.
// - Independent mode: every port register uses that port's own enable, except port A's output register in x144, which uses port B's.
// - In/out mode: input and output registers use separate enables.
// - Read/write mode: port A is the write side, port B the read side.
// - In simple dual-port, the read-enable register ignores the clear.
// - Single-port mode uses port A with one address for read and write.
// - Split single-port hosts two memories, each in half of the array.
// - Write-enable alone selects read or write; no read-enable pin exists.
// - All inputs registered; contents power up undefined, no preload.
// - Shapes 64Kx9 to 4Kx144; x144 only in simple dual-port mode.
`timescale 1ns/10ps
`default_nettype none

module ldprb_top
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ldprb_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ldprb_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ce_in_a,
  input wire logic ce_out_a,
  input wire logic clr_a,
  input wire logic wren_a,
  input wire logic [7:0] addr_lo_a,
  input wire logic [7:0] addr_hi_a,
  input wire logic [ldprb_pkg::PORT_MW-1:0] lane_en_a,
  input wire logic [ldprb_pkg::PORT_DW-1:0] wdata_a,
  output logic [ldprb_pkg::PORT_DW-1:0] rdata_a,
  input wire logic ce_in_b,
  input wire logic ce_out_b,
  input wire logic clr_b,
  input wire logic wren_b,
  input wire logic [7:0] addr_lo_b,
  input wire logic [7:0] addr_hi_b,
  input wire logic [ldprb_pkg::PORT_MW-1:0] lane_en_b,
  input wire logic [ldprb_pkg::PORT_DW-1:0] wdata_b,
  output logic [ldprb_pkg::PORT_DW-1:0] rdata_b
);

  function automatic logic [8:0] lane_get(input logic [143:0] bus,
                                          input int i, input logic l8);
    logic [8:0] v;
    if (l8)
    begin
      v = {1'b0, bus[8*i +: 8]};
    end
    else
    begin
      v = bus[9*i +: 9];
    end
    return v;
  endfunction

  function automatic logic lane_on(input int i, input logic [2:0] w);
    return (i < (1 << w));
  endfunction

  // Control register fields
  logic [12:0] ctrl_r;
  logic [2:0] width;
  logic [1:0] ram_mode;
  logic [1:0] clk_mode;
  logic lanes8;
  logic x144;
  logic sdp;
  logic [1:0] byp;
  logic [1:0] msk_use;

  assign width = ctrl_r[ldprb_pkg::CTRL_WIDTH_LSB +: 3];
  assign ram_mode = ctrl_r[ldprb_pkg::CTRL_MODE_LSB +: 2];
  assign clk_mode = ctrl_r[ldprb_pkg::CTRL_CLK_LSB +: 2];
  assign lanes8 = ctrl_r[ldprb_pkg::CTRL_LANE8];
  assign x144 = (width == ldprb_pkg::W_X144);
  assign sdp = (ram_mode == ldprb_pkg::MODE_SDP);
  assign byp = {ctrl_r[ldprb_pkg::CTRL_BYP_B], ctrl_r[ldprb_pkg::CTRL_BYP_A]};
  assign msk_use = {ctrl_r[ldprb_pkg::CTRL_MSK_B],
                    ctrl_r[ldprb_pkg::CTRL_MSK_A]};

  // Port pins gathered so both ports share one description
  logic [1:0] ce_in;
  logic [1:0] ce_out;
  logic [1:0] clr;
  logic [1:0] wren;
  logic [15:0] addr_in [2];
  logic [7:0] mask_in [2];
  logic [71:0] wd_in [2];

  assign ce_in = {ce_in_b, ce_in_a};
  assign ce_out = {ce_out_b, ce_out_a};
  assign clr = {clr_b, clr_a};
  assign wren = {wren_b, wren_a};
  assign addr_in[0] = {addr_hi_a, addr_lo_a};
  assign addr_in[1] = {addr_hi_b, addr_lo_b};
  assign mask_in[0] = lane_en_a;
  assign mask_in[1] = lane_en_b;
  assign wd_in[0] = wdata_a;
  assign wd_in[1] = wdata_b;

  // Array of 9-bit lanes; no reset, so contents start undefined
  logic [8:0] mem_r [0:ldprb_pkg::DEPTH-1];

  logic [1:0] in_en;
  logic [1:0] out_en;
  logic [15:0] addr_q [2];
  logic [7:0] mk_q [2];
  logic [71:0] wd_q [2];
  logic [1:0] we_q;
  logic [1:0] pend_q;
  logic [1:0] wr_ok;
  logic [1:0] port_on;
  logic [1:0] rd_mode;
  logic [1:0] wr_go;
  logic [7:0] mk_eff [2];
  logic [15:0] base [2];
  logic [143:0] wbus [2];
  logic [15:0] wmask [2];
  logic [15:0] lane_we [2];
  logic [143:0] rbus [2];
  logic [71:0] rd_src [2];
  logic [71:0] out_r [2];
  logic [1:0] rd_go;
  logic [15:0] wcnt_r [2];

  genvar p;
  for (p = 0; p < 2; p++)
  begin : g_port
    assign in_en[p] = ce_in[p];
    // Only input/output mode gives the output register its own enable
    assign out_en[p] = (clk_mode == ldprb_pkg::CLK_IO) ? ce_out[p] :
                       ce_in[p];

    always_ff @(posedge aclk)
    begin
      if (!aresetn || clr[p])
      begin
        addr_q[p] <= 16'h0000;
        mk_q[p] <= 8'h00;
        wd_q[p] <= 72'h0;
      end
      else if (in_en[p])
      begin
        addr_q[p] <= addr_in[p];
        mk_q[p] <= mask_in[p];
        wd_q[p] <= wd_in[p];
      end
    end

    // Port B's select acts as read enable in simple dual-port; clear skips it
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        we_q[p] <= 1'b0;
      end
      else if (clr[p] && !(sdp && p == 1))
      begin
        we_q[p] <= 1'b0;
      end
      else if (in_en[p])
      begin
        we_q[p] <= wren[p];
      end
    end

    // One array write per enabled capture, not one per cycle
    always_ff @(posedge aclk)
    begin
      if (!aresetn || clr[p])
      begin
        pend_q[p] <= 1'b0;
      end
      else
      begin
        pend_q[p] <= in_en[p];
      end
    end

    assign wr_ok[p] = (ram_mode == ldprb_pkg::MODE_TDP) ||
                      (p == 0) ||
                      (ram_mode == ldprb_pkg::MODE_SP &&
                       ctrl_r[ldprb_pkg::CTRL_SPLIT]);
    assign port_on[p] = (p == 0) || (ram_mode != ldprb_pkg::MODE_SP) ||
                        ctrl_r[ldprb_pkg::CTRL_SPLIT];
    assign rd_mode[p] = (sdp && p == 1) ? we_q[p] : !we_q[p];
    assign wr_go[p] = pend_q[p] && we_q[p] && wr_ok[p] &&
                      !(sdp && p == 1);
    assign mk_eff[p] = (width == ldprb_pkg::W_X9 || !msk_use[p]) ? 8'hff :
                       mk_q[p];

    // Lane index of the word's first lane; split halves use the top bit
    always_comb
    begin
      base[p] = 16'((32'(addr_q[p]) << width));
      if (ram_mode == ldprb_pkg::MODE_SP && ctrl_r[ldprb_pkg::CTRL_SPLIT])
      begin
        base[p][15] = (p == 1);
      end
    end

    // 8-bit lanes carry 64 bits per port, so the two halves meet at bit 64
    assign wbus[p] = !x144 ? {72'h0, wd_q[p]} :
                     lanes8 ? {16'h0, wd_q[1][63:0], wd_q[0][63:0]} :
                     {wd_q[1], wd_q[0]};
    assign wmask[p] = x144 ? {mk_eff[1], mk_eff[0]}
                           : {8'h00, mk_eff[p]};

    always_comb
    begin
      for (int i = 0; i < ldprb_pkg::NLANES; i++)
      begin
        lane_we[p][i] = wr_go[p] && wmask[p][i] &&
                        lane_on(i, width);
      end
    end

    always_comb
    begin
      rbus[p] = 144'h0;
      for (int i = 0; i < ldprb_pkg::NLANES; i++)
      begin
        if (lane_on(i, width))
        begin
          if (lanes8)
          begin
            rbus[p][8*i +: 8] = mem_r[base[p] | 16'(i)][7:0];
          end
          else
          begin
            rbus[p][9*i +: 9] = mem_r[base[p] | 16'(i)];
          end
        end
      end
    end

    // In x144 the read side is port B, its halves split over both outputs
    assign rd_go[p] = x144 ? (rd_mode[1] && out_en[1])
                           : (rd_mode[p] && out_en[p] && port_on[p]);

    always_ff @(posedge aclk)
    begin
      if (!aresetn || clr[p])
      begin
        out_r[p] <= 72'h0;
      end
      else if (rd_go[p])
      begin
        out_r[p] <= rd_src[p];
      end
    end

    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        wcnt_r[p] <= 16'h0000;
      end
      else if (wr_go[p])
      begin
        wcnt_r[p] <= wcnt_r[p] + 16'h0001;
      end
    end
  end

  assign rd_src[0] = !x144 ? rbus[0][71:0] :
                     lanes8 ? {8'h00, rbus[1][63:0]} :
                     rbus[1][71:0];
  assign rd_src[1] = !x144 ? rbus[1][71:0] :
                     lanes8 ? {8'h00, rbus[1][127:64]} :
                     rbus[1][143:72];

  // Bypass trades the output register stage for a combinational array path
  assign rdata_a = byp[0] ? rd_src[0] : out_r[0];
  assign rdata_b = byp[1] ? rd_src[1] : out_r[1];

  // Port B first so port A wins when both write one lane
  always_ff @(posedge aclk)
  begin
    for (int q = 1; q >= 0; q--)
    begin
      for (int i = 0; i < ldprb_pkg::NLANES; i++)
      begin
        if (lane_we[q][i])
        begin
          mem_r[base[q] | 16'(i)] <=
            lane_get(wbus[q], i, lanes8);
        end
      end
    end
  end

  // Rejects shapes the array cannot build
  function automatic logic cfg_ok(input logic [12:0] c);
    logic [2:0] w;
    logic [1:0] m;
    logic [1:0] k;
    w = c[ldprb_pkg::CTRL_WIDTH_LSB +: 3];
    m = c[ldprb_pkg::CTRL_MODE_LSB +: 2];
    k = c[ldprb_pkg::CTRL_CLK_LSB +: 2];
    return (w <= ldprb_pkg::W_X144) && (m != ldprb_pkg::MODE_BAD) &&
           (k != ldprb_pkg::MODE_BAD) &&
           !(w == ldprb_pkg::W_X144 && m != ldprb_pkg::MODE_SDP) &&
           !(k == ldprb_pkg::CLK_RW && m != ldprb_pkg::MODE_SDP) &&
           !(c[ldprb_pkg::CTRL_SPLIT] && m != ldprb_pkg::MODE_SP);
  endfunction

  // AXI4-Lite write side: address and data taken in either order
  logic [ldprb_pkg::AXI_AW-1:0] awaddr_r;
  logic [31:0] wdat_r;
  logic [3:0] wstrb_r;
  logic do_wr;
  logic [12:0] ctrl_nxt;
  logic err_r;
  logic err_set;
  logic err_clr;

  assign do_wr = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    if (wstrb_r[0])
    begin
      ctrl_nxt[7:0] = wdat_r[7:0];
    end
    if (wstrb_r[1])
    begin
      ctrl_nxt[12:8] = wdat_r[12:8];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      awaddr_r <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      s_axi_awready <= 1'b0;
      awaddr_r <= s_axi_awaddr;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_wready <= 1'b1;
      wdat_r <= 32'h0;
      wstrb_r <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      s_axi_wready <= 1'b0;
      wdat_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ldprb_pkg::RESP_OKAY;
    end
    else if (do_wr)
    begin
      s_axi_bvalid <= 1'b1;
      if ((awaddr_r == ldprb_pkg::REG_CTRL && cfg_ok(ctrl_nxt)) ||
          awaddr_r == ldprb_pkg::REG_STAT ||
          awaddr_r == ldprb_pkg::REG_WCNT)
      begin
        s_axi_bresp <= ldprb_pkg::RESP_OKAY;
      end
      else
      begin
        s_axi_bresp <= ldprb_pkg::RESP_SLVERR;
      end
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_r <= ldprb_pkg::CTRL_RST;
    end
    else if (do_wr && awaddr_r == ldprb_pkg::REG_CTRL && cfg_ok(ctrl_nxt))
    begin
      ctrl_r <= ctrl_nxt;
    end
  end

  assign err_set = do_wr && awaddr_r == ldprb_pkg::REG_CTRL &&
                   !cfg_ok(ctrl_nxt);
  assign err_clr = do_wr && awaddr_r == ldprb_pkg::REG_STAT &&
                   wstrb_r[0] && wdat_r[ldprb_pkg::STAT_ERR];

  // A rejection in the clearing cycle still leaves the flag set
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      err_r <= 1'b0;
    end
    else if (err_set)
    begin
      err_r <= 1'b1;
    end
    else if (err_clr)
    begin
      err_r <= 1'b0;
    end
  end

  // AXI4-Lite read side
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= ldprb_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= ldprb_pkg::RESP_OKAY;
      if (s_axi_araddr == ldprb_pkg::REG_CTRL)
      begin
        s_axi_rdata <= {19'h0, ctrl_r};
      end
      else if (s_axi_araddr == ldprb_pkg::REG_STAT)
      begin
        s_axi_rdata <= {31'h0, err_r};
      end
      else if (s_axi_araddr == ldprb_pkg::REG_WCNT)
      begin
        s_axi_rdata <= {wcnt_r[1], wcnt_r[0]};
      end
      else
      begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= ldprb_pkg::RESP_SLVERR;
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // ldprb_top

`default_nettype wire

// ### tb/ldprb_fabric.sv
`timescale 1ns/10ps
`default_nettype none

module ldprb_fabric
(
  input wire logic aclk,
  output logic ce_in,
  output logic wren,
  output logic [7:0] addr_lo,
  output logic [7:0] addr_hi,
  output logic [7:0] lane_en,
  output logic [71:0] wdata,
  output logic rd_done
);
  initial
  begin
    {ce_in, wren, rd_done, addr_hi, addr_lo, lane_en} = 27'h0;
    wdata = 72'h0;
  end

  // A read keeps the capture for a second edge so the output register loads
  task automatic op(input logic we, input logic [15:0] a,
    input logic [7:0] m, input logic [71:0] dd);
    @(posedge aclk);
    ce_in <= 1'b1;
    wren <= we;
    {addr_hi, addr_lo} <= a;
    lane_en <= m;
    wdata <= dd;
    @(posedge aclk);
    if (!we)
      @(posedge aclk);
    ce_in <= 1'b0;
    rd_done <= !we;
    // Released lines carry the inverse so stale values cannot pass
    {addr_hi, addr_lo} <= ~a;
    lane_en <= ~m;
    wdata <= ~dd;
    @(posedge aclk);
    rd_done <= 1'b0;
  endtask
endmodule // ldprb_fabric

`default_nettype wire

// ### tb/ldprb_monitor.sv
`timescale 1ns/10ps
`default_nettype none

module ldprb_monitor
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ldprb_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ce_in_a,
  input wire logic ce_in_b,
  input wire logic clr_a,
  input wire logic [ldprb_pkg::PORT_DW-1:0] rdata_a
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  reset_vals_a: assert property ($rose(aresetn) |-> s_axi_awready &&
    s_axi_wready && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid &&
    rdata_a == '0) else $error("outputs off reset values");
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not on time");
  wr_busy_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  wr_done_a: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write response not closed");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read response late");
  rd_done_a: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid && s_axi_arready) else $error("read response not closed");
  unmapped_rd_a: assert property (s_axi_arvalid && s_axi_arready &&
    !(s_axi_araddr inside {8'h00, 8'h04, 8'h08}) |=>
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  // Config writes are excluded since a bypass change alters the read path
  rdata_hold_a: assert property (!ce_in_a && !ce_in_b && !clr_a &&
    s_axi_awready && !s_axi_awvalid && $past(!ce_in_a && !ce_in_b) |=>
    $stable(rdata_a)) else $error("read data moved while idle");
endmodule // ldprb_monitor

bind ldprb_top ldprb_monitor u_mon (.*);

`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic ce_in_a, ce_out_a, clr_a, wren_a, ce_in_b, ce_out_b, clr_b, wren_b;
  logic [7:0] addr_lo_a, addr_hi_a, lane_en_a;
  logic [7:0] addr_lo_b, addr_hi_b, lane_en_b;
  logic [71:0] wdata_a, rdata_a, wdata_b, rdata_b, d;
  logic rd_done_a, rd_done_b, peek_a, lm;
  logic [71:0] mem [0:65535];
  logic [71:0] q [$];
  logic [31:0] seed;
  logic [15:0] ad;
  int tests_run, miscompares, wa, wb;

  ldprb_top uut (.*);
  ldprb_fabric fa (.aclk(aclk), .ce_in(ce_in_a), .wren(wren_a),
    .addr_lo(addr_lo_a), .addr_hi(addr_hi_a), .lane_en(lane_en_a),
    .wdata(wdata_a), .rd_done(rd_done_a));
  ldprb_fabric fb (.aclk(aclk), .ce_in(ce_in_b), .wren(wren_b),
    .addr_lo(addr_lo_b), .addr_hi(addr_hi_b), .lane_en(lane_en_b),
    .wdata(wdata_b), .rd_done(rd_done_b));

  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  function automatic logic [31:0] nx();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  function automatic logic [71:0] rd72();
    logic [95:0] t;
    t = {nx(), nx(), nx()};
    return t[71:0];
  endfunction

  // Model keeps nine-bit lanes; an 8-bit lane write stores a zero ninth bit
  function automatic logic [71:0] mrg(logic [71:0] o, logic [71:0] n,
    logic [7:0] m, logic l8);
    for (int i = 0; i < 8; i++)
      if (m[i])
        o[9*i +: 9] = l8 ? {1'b0, n[8*i +: 8]} : n[9*i +: 9];
    return o;
  endfunction

  function automatic logic [71:0] vw(logic [71:0] s, logic l8);
    logic [71:0] r;
    r = s;
    if (l8)
    begin
      r = 72'h0;
      for (int i = 0; i < 8; i++)
        r[8*i +: 8] = s[9*i +: 8];
    end
    return r;
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [71:0] s);
    logic [71:0] e;
    e = (q.size() != 0) ? q.pop_front() : 'x;
    tests_run++;
    if (s !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic lim(input int n);
    if (n >= 50)
    begin
      miscompares++;
      $display("wrong value handshake expected answer seen none");
      print_verdict();
    end
  endtask

  always @(posedge aclk)
  begin
    if (s_axi_bvalid && s_axi_bready)
      cmp("bresp", 72'(s_axi_bresp));
    if (s_axi_rvalid && s_axi_rready)
      cmp("rdata", 72'({s_axi_rresp, s_axi_rdata}));
    if (rd_done_a || peek_a)
      cmp("rdata_a", rdata_a);
    if (rd_done_b)
      cmp("rdata_b", rdata_b);
  end

  task automatic axw(input logic [7:0] a, input logic [31:0] v,
    input logic [1:0] e);
    int n;
    q.push_back(72'(e));
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    lim(n);
  endtask

  task automatic axr(input logic [7:0] a, input logic [33:0] e);
    int n;
    q.push_back(72'(e));
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
    lim(n);
  endtask

  task automatic mw(input logic pb, input logic [15:0] a,
    input logic [7:0] m, input logic um, input logic l8);
    mem[a] = mrg(mem[a], d, um ? m : 8'hff, l8);
    if (pb)
    begin
      wb++;
      fb.op(1'b1, a, m, d);
    end
    else
    begin
      wa++;
      fa.op(1'b1, a, m, d);
    end
  endtask

  // Read mode still offers inverted data, so a stray write shows up
  task automatic mr(input logic pb, input logic [15:0] a);
    q.push_back(vw(mem[a], lm));
    if (pb)
      fb.op(1'b0, a, 8'hff, ~mem[a]);
    else
      fa.op(1'b0, a, 8'hff, ~mem[a]);
  endtask

  task automatic pk(input logic c, input logic [71:0] e);
    q.push_back(e);
    @(posedge aclk);
    clr_a <= c;
    @(posedge aclk);
    clr_a <= 1'b0;
    peek_a <= 1'b1;
    @(posedge aclk);
    peek_a <= 1'b0;
  endtask

  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, clr_a, clr_b, peek_a, lm} = 6'h0;
    {ce_out_a, ce_out_b} = 2'h3;
    {s_axi_awaddr, s_axi_araddr} = 16'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    seed = 32'h4e;
    {tests_run, miscompares, wa, wb} = '0;
    d = rd72();
    ad = d[15:0];
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axr(ldprb_pkg::REG_CTRL, 34'(ldprb_pkg::CTRL_RST));
    axr(ldprb_pkg::REG_STAT, 34'h0);
    axr(8'h0c, {ldprb_pkg::RESP_SLVERR, 32'h0});
    d = rd72();
    mw(1'b0, ad, 8'h00, 1'b0, 1'b0);
    mr(1'b0, ad);
    mr(1'b1, ad);
    axw(ldprb_pkg::REG_CTRL, 32'h0c03, ldprb_pkg::RESP_OKAY);
    for (int k = 0; k < 4; k++)
    begin
      d = rd72();
      mw(k[0], ad, (k != 0) ? d[7:0] : 8'h81, 1'b1, 1'b0);
      mr(!k[0], ad);
    end
    axw(ldprb_pkg::REG_CTRL, 32'h0c83, ldprb_pkg::RESP_OKAY);
    lm = 1'b1;
    d = rd72();
    d[71:64] = mem[ad][71:64];
    mw(1'b0, ad, 8'h5a, 1'b1, 1'b1);
    mr(1'b1, ad);
    axw(ldprb_pkg::REG_CTRL, 32'h0004, ldprb_pkg::RESP_SLVERR);
    axr(ldprb_pkg::REG_CTRL, 34'h0c83);
    axr(ldprb_pkg::REG_STAT, 34'h1);
    axw(ldprb_pkg::REG_STAT, 32'h1, ldprb_pkg::RESP_OKAY);
    axr(ldprb_pkg::REG_STAT, 34'h0);
    pk(1'b1, 72'h0);
    axw(ldprb_pkg::REG_CTRL, 32'h0103, ldprb_pkg::RESP_OKAY);
    lm = 1'b0;
    mr(1'b0, ad);
    d = rd72();
    mw(1'b1, ad, 8'h00, 1'b0, 1'b0);
    pk(1'b0, mem[ad]);
    // Simple dual-port: port B may not write, port A still reads back
    axw(ldprb_pkg::REG_CTRL, 32'h000b, ldprb_pkg::RESP_OKAY);
    fb.op(1'b1, ad, 8'hff, ~mem[ad]);
    mr(1'b0, ad);
    // Input/output mode: a low output enable keeps the old read data
    axw(ldprb_pkg::REG_CTRL, 32'h0023, ldprb_pkg::RESP_OKAY);
    q.push_back(mem[ad]);
    ce_out_a <= 1'b0;
    d = rd72();
    mw(1'b0, ad, 8'h00, 1'b0, 1'b0);
    fa.op(1'b0, ad, 8'hff, ~d);
    axw(ldprb_pkg::REG_CTRL, 32'h0003, ldprb_pkg::RESP_OKAY);
    ce_out_a <= 1'b1;
    mr(1'b0, ad);
    axr(ldprb_pkg::REG_WCNT, 34'({wb[15:0], wa[15:0]}));
    @(posedge aclk);
    print_verdict();
  end
endmodule // tb_top

`default_nettype wire
